// *** inc/mhs_cfg.svh ***
// constants of the helm station supervisor: offsets, fields, timing
// assumes a 100 MHz system clock and 32-bit AXI4-Lite register access
`ifndef MHS_CFG_SVH
`define MHS_CFG_SVH
`define MHS_CLK_MHZ        100
`define MHS_FLASH_MS       250
`define MHS_MAIN_ADDR      2'h1
`define MHS_SECOND_ADDR    2'h2
`define MHS_THR_W          7
`define MHS_LEV_SPAN       254
`define MHS_NEUTRAL_BAND   8
`define MHS_SYNC_WIN_PCT   10
`define MHS_DEADBAND_PCT   2
`define MHS_TRIM_MAX       31
`define MHS_PER_W          24
`define MHS_REG_CTRL       5'h00
`define MHS_REG_STATUS     5'h04
`define MHS_REG_MAIN_PER   5'h08
`define MHS_REG_AUX_PER    5'h0c
`define MHS_CTRL_RESET     1'b1
`define MHS_CTRL_SYNC_EN   0
`define MHS_ST_ADDR_LSB    0
`define MHS_ST_OPER        2
`define MHS_ST_LOCK        3
`define MHS_ST_OVERRIDE    4
`define MHS_ST_SYNC        5
`define MHS_ST_IN_BAND     6
`define MHS_ST_VER_OK      7
`define MHS_RESP_OKAY      2'b00
`define MHS_RESP_SLVERR    2'b10
`endif

// *** inc/mhs_pkg.sv ***
// types shared by the helm station supervisor and its bench
// assumes mhs_cfg.svh sits on the include path
`include "mhs_cfg.svh"
package mhs_pkg;
	typedef struct packed {
		logic select;
		logic lock;
		logic override;
		logic shaft_match;
	} mhs_btn_t;
	typedef mhs_btn_t mhs_lamp_t;
	typedef struct packed {
		logic                  fwd;
		logic                  rev;
		logic                  brake;
		logic                  neutral_safety;
		logic [`MHS_THR_W-1:0] throttle;
	} mhs_eng_t;
	// gray along idle -> normal -> override -> sync; normal -> sync flips both bits
	typedef enum logic [1:0] {
		MODE_IDLE     = 2'b00,
		MODE_NORMAL   = 2'b01,
		MODE_OVERRIDE = 2'b11,
		MODE_SYNC     = 2'b10
	} mhs_mode_t;
endpackage : mhs_pkg

// *** rtl/mhs_helm_ctrl.sv ***
// helm station supervisor: station select, lock, warm-up, shaft match
// assumes head buttons and pickups are already synchronous to aclk
//
// Summary of operation
// [R1] brake contacts close at clutch neutral
// [R2] brake released when forward or reverse engaged
// [R3] neutral safety shares brake relay, neutral only
// [R4] pickups give one pulse per shaft turn
// [R5] transfer press hands control to that head
// [R6] select lamp lit until another station chosen
// [R7] power-up: main station active, lockout engaged
// [R8] idle until neutral levers and transfer press
// [R9] lockout press at active station; refuse others
// [R10] second lockout press releases lockout
// [R11] warm-up entered at neutral; lamp lit
// [R12] warm-up: throttle follows, clutch held neutral
// [R13] neutral safety on throughout warm-up
// [R14] warm-up exit needs neutral then press
// [R15] shaft match toggles only within 10% levers
// [R16] trim aux throttle from pickup periods
// [R17] match lamp flashes correcting, solid in band
// [R18] shaft match: main handle drives both gears
// [R19] shaft match off on version mismatch
// [R20] station address from head switches
// [R21] dead band and lever scale are parameters
`timescale 1ns/1ns
`default_nettype none
`include "mhs_cfg.svh"
module mhs_helm_ctrl #(
	parameter int N_STN      = 2,
	parameter int N_VER      = 4,
	parameter int DB_PCT     = `MHS_DEADBAND_PCT,
	parameter int WIN_PCT    = `MHS_SYNC_WIN_PCT,
	parameter int LEV_SPAN   = `MHS_LEV_SPAN,
	parameter int FLASH_CYC  = `MHS_FLASH_MS * 1000 * `MHS_CLK_MHZ
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire mhs_pkg::mhs_btn_t         btn [N_STN],
	input  wire logic [1:0]                stn_addr [N_STN],
	input  wire logic signed [`MHS_THR_W:0] lever_main [N_STN],
	input  wire logic signed [`MHS_THR_W:0] lever_aux [N_STN],
	input  wire logic                      pickup_main,
	input  wire logic                      pickup_aux,
	input  wire logic [7:0]                comp_ver [N_VER],
	output var  mhs_pkg::mhs_lamp_t        lamp [N_STN],
	output var  mhs_pkg::mhs_eng_t         eng_main,
	output var  mhs_pkg::mhs_eng_t         eng_aux,
	input  wire logic [4:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [4:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready
);
	import mhs_pkg::*;

	localparam int TW  = `MHS_THR_W;
	localparam int PW  = `MHS_PER_W;
	localparam int IW  = (N_STN > 1) ? $clog2(N_STN) : 1;
	localparam int FW  = $clog2(FLASH_CYC + 1);

	if (N_STN < 2 || N_STN > 3)
		$error("N_STN must be 2 or 3");
	if (N_VER < 2 || DB_PCT < 0 || WIN_PCT < 0 || LEV_SPAN < 1)
		$error("bad version count, band or lever scale");
	if (FLASH_CYC < 1)
		$error("FLASH_CYC must be at least 1");

	function automatic logic [TW-1:0] lev_mag(input logic signed [TW:0] l);
		logic [TW:0] m;
		m = l[TW] ? TW'(0) - l : l;
		lev_mag = m[TW] ? {TW{1'b1}} : m[TW-1:0];
	endfunction : lev_mag

	function automatic logic lev_neutral(input logic signed [TW:0] l);
		lev_neutral = lev_mag(l) <= TW'(`MHS_NEUTRAL_BAND);
	endfunction : lev_neutral

	mhs_mode_t        mode;
	mhs_mode_t        next_mode;
	logic [1:0]       active_addr;
	logic [1:0]       next_active_addr;
	logic             lock;
	logic             sync_en;
	mhs_btn_t         btn_prev [N_STN];
	mhs_btn_t         press    [N_STN];
	logic [IW-1:0]    act_idx;
	logic [IW-1:0]    sel_idx;
	logic             sel_hit;
	logic             act_neutral;
	logic             win_ok;
	logic             ver_ok;
	logic             in_band;
	logic [PW-1:0]    period [2];
	logic             shaft_edge [2];
	logic signed [5:0] trim;
	logic [FW-1:0]    flash_cnt;
	logic             flash;
	mhs_eng_t         next_main;
	mhs_eng_t         next_aux;

	// button edges and shaft periods, one copy per station or shaft
	for (genvar i = 0; i < N_STN; i++)
	begin : g_btn
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				btn_prev[i] <= '0;
			else
				btn_prev[i] <= btn[i];
		end
		assign press[i] = btn[i] & ~btn_prev[i];
	end

	for (genvar s = 0; s < 2; s++)
	begin : g_shaft
		logic          pick_prev;
		logic [PW-1:0] cnt;
		logic          pick;
		assign pick = (s == 0) ? pickup_main : pickup_aux;
		assign shaft_edge[s] = pick & ~pick_prev;
		// one pulse per turn, so the gap between edges is the period
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				pick_prev <= 1'b0;
				cnt       <= '0;
				period[s] <= '0;
			end
			else
			begin
				pick_prev <= pick;
				if (shaft_edge[s])
				begin
					period[s] <= cnt; // [R4]
					cnt       <= PW'(1);
				end
				else if (cnt != {PW{1'b1}})
					cnt <= cnt + PW'(1);
			end
		end
	end

	// which head holds control, and the lowest station pressing select
	always_comb
	begin
		act_idx = '0;
		sel_idx = '0;
		sel_hit = 1'b0;
		for (int i = N_STN - 1; i >= 0; i--)
		begin
			if (stn_addr[i] == active_addr) // [R20]
				act_idx = IW'(i);
			// lock refuses every head but the active one
			if (press[i].select && (!lock || stn_addr[i] == active_addr))
			begin // [R9]
				sel_idx = IW'(i);
				sel_hit = 1'b1;
			end
		end
	end

	assign act_neutral = lev_neutral(lever_main[act_idx]) &&
		lev_neutral(lever_aux[act_idx]);

	always_comb
	begin
		logic [31:0] d;
		d = 32'(int'(lever_main[act_idx]) - int'(lever_aux[act_idx]));
		if (d[31])
			d = 32'h0 - d;
		win_ok = (d * 32'd100) <= 32'(WIN_PCT * LEV_SPAN); // [R15] [R21]
	end

	always_comb
	begin
		ver_ok = 1'b1;
		for (int v = 1; v < N_VER; v++)
			if (comp_ver[v] != comp_ver[0])
				ver_ok = 1'b0;
	end

	always_comb
	begin
		logic [31:0] pm;
		logic [31:0] pa;
		logic [31:0] df;
		pm = 32'(period[0]);
		pa = 32'(period[1]);
		df = (pa > pm) ? pa - pm : pm - pa;
		in_band = (pm != 32'h0) && (pa != 32'h0) &&
			(df * 32'd100 <= pm * 32'(DB_PCT)); // [R21]
	end

	// mode machine: override and shaft match presses only count at the active head; select counts at any head unless locked
	always_comb
	begin
		next_mode        = mode;
		next_active_addr = active_addr;
		if (sel_hit && (mode != MODE_IDLE ||
			(lev_neutral(lever_main[sel_idx]) &&
			lev_neutral(lever_aux[sel_idx]))))
		begin // [R5] [R8]
			next_active_addr = stn_addr[sel_idx];
			if (mode == MODE_IDLE)
				next_mode = MODE_NORMAL;
		end
		unique case (mode)
			MODE_IDLE:
				;
			MODE_NORMAL:
				if (press[act_idx].override && act_neutral)
					next_mode = MODE_OVERRIDE; // [R11]
				else if (press[act_idx].shaft_match && win_ok &&
					ver_ok && sync_en)
					next_mode = MODE_SYNC; // [R15]
			MODE_OVERRIDE:
				if (press[act_idx].override && act_neutral)
					next_mode = MODE_NORMAL; // [R14]
			MODE_SYNC:
				if (!ver_ok || !sync_en)
					next_mode = MODE_NORMAL; // [R19]
				else if (press[act_idx].shaft_match && win_ok)
					next_mode = MODE_NORMAL; // [R15]
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode        <= MODE_IDLE; // [R8]
			active_addr <= `MHS_MAIN_ADDR; // [R7]
		end
		else
		begin
			mode        <= next_mode;
			active_addr <= next_active_addr;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock <= 1'b1; // [R7]
		else if (press[act_idx].lock)
			lock <= ~lock; // [R9] [R10]
	end

	// trim integrates per aux turn; slow response avoids hunting
	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode != MODE_SYNC)
			trim <= '0;
		else if (shaft_edge[1] && !in_band)
		begin // [R16]
			if (period[1] > period[0] && trim < 6'sd`MHS_TRIM_MAX)
				trim <= trim + 6'sd1;
			else if (period[1] < period[0] && trim > -6'sd`MHS_TRIM_MAX)
				trim <= trim - 6'sd1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || flash_cnt == FW'(FLASH_CYC - 1))
			flash_cnt <= '0;
		else
			flash_cnt <= flash_cnt + FW'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flash <= 1'b0;
		else if (flash_cnt == FW'(FLASH_CYC - 1))
			flash <= ~flash;
	end

	// clutch, throttle and relay for both engines
	always_comb
	begin
		logic signed [TW:0] lm;
		logic signed [TW:0] la;
		logic [TW+1:0]      sum;
		sum = '0;
		lm = lever_main[act_idx];
		la = (mode == MODE_SYNC) ? lm : lever_aux[act_idx]; // [R18]
		next_main = '0;
		next_aux  = '0;
		next_main.throttle = lev_mag(lm);
		next_aux.throttle  = lev_mag(lever_aux[act_idx]);
		unique case (mode)
			MODE_IDLE:
			begin
				next_main.throttle = '0;
				next_aux.throttle  = '0;
			end
			MODE_OVERRIDE:
				; // [R12]
			MODE_NORMAL, MODE_SYNC:
			begin
				next_main.fwd = !lev_neutral(lm) && !lm[TW];
				next_main.rev = !lev_neutral(lm) && lm[TW];
				next_aux.fwd  = !lev_neutral(la) && !la[TW];
				next_aux.rev  = !lev_neutral(la) && la[TW];
			end
		endcase
		if (mode == MODE_SYNC)
		begin // [R16]
			sum = (TW+2)'(lev_mag(lm)) + (TW+2)'(signed'(trim));
			if (sum[TW+1])
				next_aux.throttle = '0;
			else if (sum[TW])
				next_aux.throttle = {TW{1'b1}};
			else
				next_aux.throttle = sum[TW-1:0];
		end
		// one relay per engine: brake and neutral safety together
		next_main.brake          = !(next_main.fwd || next_main.rev); // [R1] [R2]
		next_main.neutral_safety = next_main.brake; // [R3] [R13]
		next_aux.brake           = !(next_aux.fwd || next_aux.rev); // [R1] [R2]
		next_aux.neutral_safety  = next_aux.brake; // [R3] [R13]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			eng_main <= '{1'b0, 1'b0, 1'b1, 1'b1, '0};
			eng_aux  <= '{1'b0, 1'b0, 1'b1, 1'b1, '0};
		end
		else
		begin
			eng_main <= next_main;
			eng_aux  <= next_aux;
		end
	end

	for (genvar i = 0; i < N_STN; i++)
	begin : g_lamp
		logic here;
		assign here = stn_addr[i] == active_addr;
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				lamp[i] <= '0;
			else
			begin
				lamp[i].select      <= here && mode != MODE_IDLE; // [R6]
				lamp[i].lock        <= here && lock; // [R9] [R10]
				lamp[i].override    <= here && mode == MODE_OVERRIDE; // [R11]
				lamp[i].shaft_match <= here && mode == MODE_SYNC &&
					(in_band || flash); // [R17]
			end
		end
	end

	// AXI4-Lite slave: address and data taken in either order
	logic [4:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MHS_RESP_OKAY;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr[4] || aw_addr[1:0] != 2'h0) ?
					`MHS_RESP_SLVERR : `MHS_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_en <= `MHS_CTRL_RESET;
		else if (wr_go && aw_addr == `MHS_REG_CTRL && w_strb[0])
			sync_en <= w_data[`MHS_CTRL_SYNC_EN];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `MHS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `MHS_RESP_OKAY;
			s_axi_rdata   <= '0;
			unique case (s_axi_araddr)
				`MHS_REG_CTRL:
					s_axi_rdata[`MHS_CTRL_SYNC_EN] <= sync_en;
				`MHS_REG_STATUS:
				begin
					s_axi_rdata[`MHS_ST_ADDR_LSB+:2] <= active_addr;
					s_axi_rdata[`MHS_ST_OPER]     <= mode != MODE_IDLE;
					s_axi_rdata[`MHS_ST_LOCK]     <= lock;
					s_axi_rdata[`MHS_ST_OVERRIDE] <= mode == MODE_OVERRIDE;
					s_axi_rdata[`MHS_ST_SYNC]     <= mode == MODE_SYNC;
					s_axi_rdata[`MHS_ST_IN_BAND]  <= in_band;
					s_axi_rdata[`MHS_ST_VER_OK]   <= ver_ok;
				end
				`MHS_REG_MAIN_PER:
					s_axi_rdata <= 32'(period[0]);
				`MHS_REG_AUX_PER:
					s_axi_rdata <= 32'(period[1]);
				default:
					s_axi_rresp <= `MHS_RESP_SLVERR;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : mhs_helm_ctrl
`default_nettype wire

// *** testbench/mhs_props.sv ***
// checker on the helm supervisor ports: relay, lamps, lockout
// assumes mhs_pkg is compiled first; bound into each design instance
`timescale 1ns/1ns
`default_nettype none
module mhs_props #(
	parameter int N_STN = 2
) (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire mhs_pkg::mhs_btn_t  btn [N_STN],
	input wire mhs_pkg::mhs_lamp_t lamp [N_STN],
	input wire mhs_pkg::mhs_eng_t  eng_main,
	input wire mhs_pkg::mhs_eng_t  eng_aux
);
	import mhs_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_lock0;
		lamp[0].select && $rose(btn[0].lock);
	endsequence
	sequence s_sel1;
		lamp[0].select && $rose(btn[1].select) && !btn[0].select;
	endsequence
	property p_brake_on;
		!(eng_main.fwd || eng_main.rev) |-> eng_main.brake;
	endproperty
	a_brake_on: assert property (p_brake_on)
		else $error("brake open at clutch neutral");
	property p_brake_off;
		eng_main.fwd || eng_main.rev |-> !eng_main.brake;
	endproperty
	a_brake_off: assert property (p_brake_off)
		else $error("brake held with gear engaged");
	property p_relay;
		eng_main.neutral_safety == eng_main.brake &&
		eng_aux.neutral_safety == eng_aux.brake &&
		eng_aux.brake == !(eng_aux.fwd || eng_aux.rev);
	endproperty
	a_relay: assert property (p_relay)
		else $error("safety output not on the brake relay");
	property p_warm;
		lamp[0].override || lamp[1].override |->
			!(eng_main.fwd || eng_main.rev || eng_aux.fwd || eng_aux.rev)
			&& eng_main.neutral_safety;
	endproperty
	a_warm: assert property (p_warm)
		else $error("clutch left neutral in warm-up");
	property p_lock_on;
		s_lock0 ##0 !lamp[0].lock |-> ##[2:3] lamp[0].lock;
	endproperty
	a_lock_on: assert property (p_lock_on)
		else $error("lockout did not engage");
	property p_lock_off;
		s_lock0 ##0 lamp[0].lock |-> ##[2:3] !lamp[0].lock;
	endproperty
	a_lock_off: assert property (p_lock_off)
		else $error("lockout did not release");
	property p_refuse;
		s_sel1 ##0 lamp[0].lock |=> lamp[0].select [*4];
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("select taken while locked");
	property p_move;
		s_sel1 ##0 !lamp[0].lock |-> ##[2:3] lamp[1].select && !lamp[0].select;
	endproperty
	a_move: assert property (p_move)
		else $error("control not handed over");
	property p_hold;
		$fell(lamp[0].select) |-> lamp[1].select;
	endproperty
	a_hold: assert property (p_hold)
		else $error("select lamp dropped without transfer");
endmodule : mhs_props
bind mhs_helm_ctrl mhs_props #(.N_STN(N_STN)) i_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.btn(btn),
	.lamp(lamp),
	.eng_main(eng_main),
	.eng_aux(eng_aux)
);
`default_nettype wire

// *** testbench/mhs_far_model.sv ***
// far side: head address switches and the two shaft pickups
// assumes periods of two cycles or more, set by the bench
`timescale 1ns/1ns
`default_nettype none
module mhs_far_model (
	input  wire logic        aclk,
	input  wire logic [15:0] per_main,
	input  wire logic [15:0] per_aux,
	output logic             pickup_main,
	output logic             pickup_aux,
	output logic [1:0]       stn_addr [2]
);
	int cnt_m = 0;
	int cnt_a = 0;
	assign stn_addr[0] = 2'h1;
	assign stn_addr[1] = 2'h2;
	// pickup is a one-cycle pulse, so only rising edges matter
	always @(posedge aclk)
	begin
		cnt_m <= (cnt_m >= per_main - 1) ? 0 : cnt_m + 1;
		cnt_a <= (cnt_a >= per_aux - 1) ? 0 : cnt_a + 1;
		pickup_main <= (cnt_m == 0);
		pickup_aux <= (cnt_a == 0);
	end
endmodule : mhs_far_model
`default_nettype wire

// *** testbench/marine_helm_station_control_logic_tb_top.sv ***
// self-checking bench for the helm station supervisor
// assumes mhs_pkg, the design, its checker and the far-side model
`timescale 1ns/1ns
`default_nettype none
`include "mhs_cfg.svh"
module marine_helm_station_control_logic_tb_top;
	import mhs_pkg::*;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	mhs_btn_t          btn [2];
	logic [1:0]        stn_addr [2];
	logic signed [7:0] lev_m [2];
	logic signed [7:0] lev_a [2];
	logic              pk_m;
	logic              pk_a;
	logic [7:0]        comp_ver [4];
	mhs_lamp_t         lamp [2];
	mhs_eng_t          eng_m;
	mhs_eng_t          eng_a;
	logic [15:0]       per_m = 16'h0032;
	logic [15:0]       per_a = 16'h0032;
	logic [4:0]        awaddr = 5'h00;
	logic [4:0]        araddr = 5'h00;
	logic [31:0]       wdata = 32'h0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              arvalid = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	int                err_total = 0;
	int                n_compared = 0;
	int                act = 0;
	int                lm [2] = '{0, 0};
	int                la [2] = '{0, 0};
	bit                oper = 0, lock = 1, ovr = 0, sy = 0, ven = 1, vok = 1;
	logic [31:0]       xs_st = 32'h0000004a;
	always #5 aclk = ~aclk;
	mhs_far_model i_far (.aclk(aclk), .per_main(per_m), .per_aux(per_a),
		.pickup_main(pk_m), .pickup_aux(pk_a), .stn_addr(stn_addr));
	mhs_helm_ctrl #(.FLASH_CYC(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.btn(btn), .stn_addr(stn_addr), .lever_main(lev_m),
		.lever_aux(lev_a), .pickup_main(pk_m), .pickup_aux(pk_a),
		.comp_ver(comp_ver), .lamp(lamp), .eng_main(eng_m), .eng_aux(eng_a),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
	function logic [31:0] xs();
		xs_st ^= xs_st << 13;
		xs_st ^= xs_st >> 17;
		xs_st ^= xs_st << 5;
		return xs_st;
	endfunction : xs
	function int mag(int l);
		return l < 0 ? -l : l;
	endfunction : mag
	function bit neu(int l);
		return mag(l) <= `MHS_NEUTRAL_BAND;
	endfunction : neu
	// clutch bits {fwd, rev, brake, safety} expected for a handle
	function logic [3:0] gear(int l);
		if (ovr || !oper || neu(l))
			return 4'h3;
		return l > 0 ? 4'h8 : 4'h4;
	endfunction : gear
	task close_out();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw;
		bit w;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && awready)
			begin
				aw = 0;
				awvalid <= 1'b0;
			end
			if (w && wready)
			begin
				w = 0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
	endtask : wr
	task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd
	task st_chk();
		logic [31:0] d;
		logic [1:0]  r;
		rd(`MHS_REG_STATUS, d, r);
		chk(r, `MHS_RESP_OKAY);
		chk({d[7], d[5:0]}, {vok, sy, ovr, lock, oper, act ? 2'h2 : 2'h1});
		if (oper)
			chk(lamp[act][3:1], {1'b1, lock, ovr});
		chk(lamp[1 - act][3:1], 3'h0);
	endtask : st_chk
	task eng_chk(int m, int a);
		chk(eng_m[10:7], gear(m));
		chk(eng_a[10:7], gear(sy ? m : a));
		if (oper && !sy && !neu(m))
			chk(eng_m.throttle, mag(m));
		if (oper && !sy)
			chk(eng_a.throttle, mag(a));
	endtask : eng_chk
	task set(int i, int m, int a);
		lm[i] = m;
		la[i] = a;
		lev_m[i] <= 8'(m);
		lev_a[i] <= 8'(a);
		repeat (4) @(posedge aclk);
	endtask : set
	task hit(int i, mhs_btn_t b);
		bit both_neu;
		both_neu = neu(lm[i]) && neu(la[i]);
		if (b.select && (!lock || i == act) && (oper || both_neu))
		begin
			act = i;
			oper = 1;
		end
		if (b.lock && i == act)
			lock ^= 1;
		if (b.override && i == act && oper && !sy && both_neu)
			ovr ^= 1;
		if (b.shaft_match && i == act && oper && !ovr && ven && vok &&
			mag(lm[i] - la[i]) * 100 <= `MHS_SYNC_WIN_PCT * `MHS_LEV_SPAN)
			sy ^= 1;
		btn[i] <= b;
		repeat (2) @(posedge aclk);
		btn[i] <= 4'h0;
		repeat (4) @(posedge aclk);
	endtask : hit
	task flash(output int n);
		n = 0;
		repeat (16)
		begin
			@(posedge aclk);
			n += lamp[0].shaft_match;
		end
	endtask : flash
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_total++;
		close_out();
	end
	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		int          m;
		foreach (btn[i])
			btn[i] = 4'h0;
		foreach (lev_m[i])
			lev_m[i] = 8'h00;
		foreach (lev_a[i])
			lev_a[i] = 8'h00;
		foreach (comp_ver[i])
			comp_ver[i] = 8'h11;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(eng_m, 11'h180);
		st_chk();
		rd(`MHS_REG_CTRL, d, r);
		chk(d[0], 1'b1);
		rd(5'h10, d, r);
		chk(r, `MHS_RESP_SLVERR);
		wr(5'h10, 32'h0, r);
		chk(r, `MHS_RESP_SLVERR);
		set(0, 9 + xs() % 119, 0);
		hit(0, 4'h8);
		st_chk();
		eng_chk(lm[0], 0);
		set(0, xs() % 17 - 8, xs() % 17 - 8);
		hit(0, 4'h8);
		st_chk();
		for (int k = 0; k < 6; k++)
		begin
			m = (k % 3 == 2) ? xs() % 17 - 8 : 9 + xs() % 119;
			m = (k % 3 == 1) ? -m : m;
			set(0, m, -m);
			eng_chk(m, -m);
		end
		set(0, 0, 0);
		hit(1, 4'h8);
		st_chk();
		hit(0, 4'h4);
		hit(1, 4'h8);
		st_chk();
		hit(1, 4'h4);
		hit(0, 4'h8);
		st_chk();
		hit(1, 4'h4);
		hit(0, 4'h8);
		hit(0, 4'h4);
		st_chk();
		set(0, 50, 50);
		hit(0, 4'h2);
		st_chk();
		set(0, 0, 0);
		hit(0, 4'h2);
		st_chk();
		m = 9 + xs() % 119;
		set(0, m, m);
		eng_chk(m, m);
		hit(0, 4'h2);
		st_chk();
		set(0, 0, 0);
		hit(0, 4'h2);
		st_chk();
		set(0, 60, 88);
		hit(0, 4'h1);
		st_chk();
		set(0, 60, 85);
		hit(0, 4'h1);
		st_chk();
		per_a <= 16'h003c;
		repeat (400) @(posedge aclk);
		chk(eng_a.throttle > eng_m.throttle, 1'b1);
		flash(m);
		chk(m > 0 && m < 16, 1'b1);
		set(0, 60, -60);
		eng_chk(60, -60);
		per_a <= 16'h0032;
		repeat (300) @(posedge aclk);
		rd(`MHS_REG_STATUS, d, r);
		chk(d[6], 1'b1);
		flash(m);
		chk(m, 16);
		rd(`MHS_REG_MAIN_PER, d, r);
		chk(d, 32'(per_m));
		rd(`MHS_REG_AUX_PER, d, r);
		chk(d, 32'(per_a));
		comp_ver[1] <= 8'h12;
		repeat (4) @(posedge aclk);
		vok = 0;
		sy = 0;
		st_chk();
		comp_ver[1] <= 8'h11;
		repeat (4) @(posedge aclk);
		vok = 1;
		set(0, 60, 60);
		hit(0, 4'h1);
		wr(`MHS_REG_CTRL, 32'h0, r);
		chk(r, `MHS_RESP_OKAY);
		rd(`MHS_REG_CTRL, d, r);
		chk(d[0], 1'b0);
		sy = 0;
		ven = 0;
		hit(0, 4'h1);
		st_chk();
		close_out();
	end
endmodule : marine_helm_station_control_logic_tb_top
`default_nettype wire
